//--- hwf_device.sv
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "hwf_defines.svh"
module hwf_device #(
	parameter int SETS   = 128,
	parameter int NUNITS = 4
) (
	input  wire logic              CLK,
	input  wire logic              RST_N,
	hwf_link_if.dev                LINK,
	input  wire logic              SPR_WE,
	input  wire logic [31:0]       SPR_WDATA,
	output logic      [31:0]       SPR_RDATA,
	input  wire logic              MACHINE_STATE_LOWPWR_BIT,
	input  wire logic              WAKE,
	input  wire logic              HARD_RESET_N,
	input  wire logic              CLKOUT_TYPE_SEL_B,
	output logic                   CLK_OUT_EN,
	output logic      [1:0]        CLK_OUT_SEL,
	output hwf_pkg::hwf_pwr_t      PWR_STATE,
	output logic                   CORE_ACTIVE,
	output logic                   SNOOP_ACTIVE,
	output logic                   PLL_TB_ACTIVE,
	input  wire logic [NUNITS-1:0] UNIT_IDLE,
	output logic      [NUNITS-1:0] UNIT_LOWPWR,
	input  wire logic              RETRY_REQ,
	input  wire logic              ACC_VALID,
	input  wire logic              ACC_INSTR,
	input  wire logic [$clog2(SETS)-1:0] ACC_SET,
	input  wire logic              ACC_WAY,
	input  wire logic              ACC_TAG_HIT,
	input  wire logic              ACC_XLATE_CI,
	output logic                   RES_VALID,
	output logic                   RES_HIT,
	output logic                   RES_FILL,
	output logic                   RES_SINGLE_BEAT,
	output logic                   CACHE_INHIBIT_PIN,
	input  wire logic              SNP_VALID,
	input  wire logic              SNP_INSTR,
	input  wire logic [$clog2(SETS)-1:0] SNP_SET,
	input  wire logic              SNP_WAY,
	input  wire logic              SNP_TAG_HIT,
	input  wire logic              SNP_KILL,
	output logic                   SNP_HIT,
	output logic                   FLUSH_BUSY
);
	import hwf_pkg::*;

	localparam int SW = $clog2(SETS);

	typedef struct packed {
		logic [31:0]       ctl;
		logic [31:0]       rdata;
		hwf_pwr_t          pwr;
		logic              pow_q;
		logic [7:0]        slp_cnt;
		logic              qreq_n;
		logic [1:0]        rty_ph;
		logic              rty_o;
		logic              rty_oe_n;
		logic              fl_busy;
		logic [SW-1:0]     fl_set;
		logic [2*SETS-1:0] ic_v;
		logic [2*SETS-1:0] dc_v;
		logic [SETS-1:0]   ic_lru;
		logic [SETS-1:0]   dc_lru;
		logic              res_valid;
		logic              res_hit;
		logic              res_fill;
		logic              res_single;
		logic              res_ci;
		logic              snp_hit;
		logic              clk_en;
		logic [1:0]        clk_sel;
		logic [NUNITS-1:0] unit_lp;
		logic              core_act;
		logic              snp_act;
		logic              pll_act;
	} hwf_dev_st_t;

	hwf_dev_st_t st_r;
	hwf_dev_st_t st_nxt;

	function automatic int unsigned vidx(input logic [SW-1:0] set, input logic way);
		vidx = 32'({set, way});
	endfunction : vidx

	logic acc_en;
	logic acc_lock;
	logic acc_blk;
	logic acc_vbit;
	logic acc_hit;
	logic acc_fill;
	logic snp_en;
	logic snp_vbit;
	logic snp_hit;
	logic pow_rise;

	always_comb begin
		st_nxt = st_r;

		// ----------------------------------------------------------------
		// register write and readback
		// ----------------------------------------------------------------
		if (SPR_WE)
			st_nxt.ctl = SPR_WDATA & `HWF_WR_MASK;

		// ----------------------------------------------------------------
		// flash invalidate of the instruction cache
		// ----------------------------------------------------------------
		if (st_r.fl_busy) begin
			st_nxt.ic_v[vidx(st_r.fl_set, 1'b0)] = 1'b0;
			st_nxt.ic_v[vidx(st_r.fl_set, 1'b1)] = 1'b0;
			st_nxt.ic_lru[st_r.fl_set]           = 1'b0;
			st_nxt.fl_set  = st_r.fl_set + 1'b1;
			st_nxt.fl_busy = (st_r.fl_set != SW'(SETS - 1));
		end else if (st_r.ctl[`HWF_B_INSTR_CACHE_FLUSH_ALL] && st_r.ctl[`HWF_B_ICE]) begin
			st_nxt.fl_busy = 1'b1;
			st_nxt.fl_set  = '0;
			if (!SPR_WE)
				st_nxt.ctl[`HWF_B_INSTR_CACHE_FLUSH_ALL] = 1'b0;
		end

		// ----------------------------------------------------------------
		// cache access decision
		// ----------------------------------------------------------------
		acc_en   = ACC_INSTR ? st_r.ctl[`HWF_B_ICE] : st_r.ctl[`HWF_B_DCE];
		acc_lock = ACC_INSTR ? st_r.ctl[`HWF_B_INSTR_CACHE_FREEZE] : st_r.ctl[`HWF_B_DATA_CACHE_FREEZE];
		acc_blk  = ACC_INSTR && st_r.fl_busy;
		acc_vbit = ACC_INSTR ? st_r.ic_v[vidx(ACC_SET, ACC_WAY)]
		                     : st_r.dc_v[vidx(ACC_SET, ACC_WAY)];
		acc_hit  = ACC_VALID && acc_en && !acc_blk && ACC_TAG_HIT && acc_vbit;
		acc_fill = ACC_VALID && acc_en && !acc_blk && !acc_hit && !acc_lock
		           && !ACC_XLATE_CI;
		st_nxt.res_valid  = ACC_VALID;
		st_nxt.res_hit    = acc_hit;
		st_nxt.res_fill   = acc_fill;
		st_nxt.res_single = ACC_VALID && !acc_hit && !acc_fill;
		st_nxt.res_ci     = ACC_VALID ? ACC_XLATE_CI : st_r.res_ci;
		if (acc_fill || acc_hit) begin
			if (ACC_INSTR) begin
				st_nxt.ic_v[vidx(ACC_SET, ACC_WAY)] = 1'b1;
				st_nxt.ic_lru[ACC_SET] = ~ACC_WAY;
			end else begin
				st_nxt.dc_v[vidx(ACC_SET, ACC_WAY)] = 1'b1;
				st_nxt.dc_lru[ACC_SET] = ~ACC_WAY;
			end
		end

		// ----------------------------------------------------------------
		// snoop handling, same in locked and unlocked cache
		// ----------------------------------------------------------------
		snp_en   = SNP_INSTR ? (st_r.ctl[`HWF_B_ICE] && !st_r.fl_busy)
		                     : st_r.ctl[`HWF_B_DCE];
		snp_vbit = SNP_INSTR ? st_r.ic_v[vidx(SNP_SET, SNP_WAY)]
		                     : st_r.dc_v[vidx(SNP_SET, SNP_WAY)];
		snp_hit  = SNP_VALID && snp_en && SNP_TAG_HIT && snp_vbit
		           && (st_r.pwr == PWR_RUN || st_r.pwr == PWR_DOZE);
		st_nxt.snp_hit = snp_hit;
		if (snp_hit && SNP_KILL) begin
			if (SNP_INSTR)
				st_nxt.ic_v[vidx(SNP_SET, SNP_WAY)] = 1'b0;
			else
				st_nxt.dc_v[vidx(SNP_SET, SNP_WAY)] = 1'b0;
		end

		// ----------------------------------------------------------------
		// power modes
		// ----------------------------------------------------------------
		st_nxt.pow_q = MACHINE_STATE_LOWPWR_BIT;
		pow_rise = MACHINE_STATE_LOWPWR_BIT && !st_r.pow_q;
		unique case (st_r.pwr)
			PWR_RUN: begin
				if (pow_rise && st_r.ctl[`HWF_B_SLEEP]) begin
					st_nxt.pwr    = PWR_SLPREQ;
					st_nxt.qreq_n = 1'b0;
				end else if (pow_rise && st_r.ctl[`HWF_B_NAP])
					st_nxt.pwr = PWR_NAP;
				else if (pow_rise && st_r.ctl[`HWF_B_DOZE])
					st_nxt.pwr = PWR_DOZE;
			end
			PWR_DOZE, PWR_NAP, PWR_SLEEP: begin
				if (WAKE) begin
					st_nxt.pwr    = PWR_RUN;
					st_nxt.qreq_n = 1'b1;
				end
			end
			PWR_SLPREQ: begin
				if (WAKE) begin
					st_nxt.pwr    = PWR_RUN;
					st_nxt.qreq_n = 1'b1;
				end else if (!LINK.quiesce_grant_n) begin
					st_nxt.pwr     = PWR_SLPWT;
					st_nxt.slp_cnt = '0;
				end
			end
			PWR_SLPWT: begin
				st_nxt.slp_cnt = st_r.slp_cnt + 8'h01;
				if (st_r.slp_cnt == `HWF_SLEEP_DELAY - 8'h01)
					st_nxt.pwr = PWR_SLEEP;
			end
			default: st_nxt.pwr = PWR_RUN;
		endcase

		// ----------------------------------------------------------------
		// retry line drive and precharge
		// ----------------------------------------------------------------
		unique case (st_r.rty_ph)
			2'd0: begin
				if (RETRY_REQ) begin
					st_nxt.rty_ph   = 2'd1;
					st_nxt.rty_o    = 1'b0;
					st_nxt.rty_oe_n = 1'b0;
				end
			end
			2'd1: begin
				st_nxt.rty_ph   = 2'd2;
				st_nxt.rty_o    = 1'b1;
				st_nxt.rty_oe_n = st_r.ctl[`HWF_B_NOPRE];
			end
			default: begin
				st_nxt.rty_ph   = 2'd0;
				st_nxt.rty_oe_n = 1'b1;
			end
		endcase

		// ----------------------------------------------------------------
		// clock-out select and dynamic power
		// ----------------------------------------------------------------
		if (!HARD_RESET_N) begin
			st_nxt.clk_en  = 1'b1;
			st_nxt.clk_sel = `HWF_CLK_HARD_RESET_N;
		end else begin
			st_nxt.clk_sel = {CLKOUT_TYPE_SEL_B, st_r.ctl[`HWF_B_CLKSEL]};
			st_nxt.clk_en  = CLKOUT_TYPE_SEL_B || st_r.ctl[`HWF_B_CLKSEL];
		end
		st_nxt.unit_lp = st_r.ctl[`HWF_B_DPM] ? UNIT_IDLE : '0;
		st_nxt.rdata   = st_nxt.ctl;
		// activity flags registered from the next state so they track PWR_STATE
		st_nxt.core_act = (st_nxt.pwr == PWR_RUN);
		st_nxt.snp_act  = (st_nxt.pwr == PWR_RUN) || (st_nxt.pwr == PWR_DOZE);
		st_nxt.pll_act  = (st_nxt.pwr != PWR_SLEEP);
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			st_r          <= '0;
			st_r.ctl      <= `HWF_CTL_RESET;
			st_r.pwr      <= PWR_RUN;
			st_r.qreq_n   <= 1'b1;
			st_r.rty_o    <= 1'b1;
			st_r.rty_oe_n <= 1'b1;
			st_r.core_act <= 1'b1;
			st_r.snp_act  <= 1'b1;
			st_r.pll_act  <= 1'b1;
		end else
			st_r <= st_nxt;
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign SPR_RDATA              = st_r.rdata;
	assign CLK_OUT_EN             = st_r.clk_en;
	assign CLK_OUT_SEL            = st_r.clk_sel;
	assign PWR_STATE              = st_r.pwr;
	assign CORE_ACTIVE            = st_r.core_act;
	assign SNOOP_ACTIVE           = st_r.snp_act;
	assign PLL_TB_ACTIVE          = st_r.pll_act;
	assign UNIT_LOWPWR            = st_r.unit_lp;
	assign RES_VALID              = st_r.res_valid;
	assign RES_HIT                = st_r.res_hit;
	assign RES_FILL               = st_r.res_fill;
	assign RES_SINGLE_BEAT        = st_r.res_single;
	assign CACHE_INHIBIT_PIN      = st_r.res_ci;
	assign SNP_HIT                = st_r.snp_hit;
	assign FLUSH_BUSY             = st_r.fl_busy;
	assign LINK.quiesce_request_n = st_r.qreq_n;
	assign LINK.retry_dev_o       = st_r.rty_o;
	assign LINK.retry_dev_oe_n    = st_r.rty_oe_n;

endmodule : hwf_device

//--- hwf_defines.svh
`ifndef HWF_DEFINES_SVH
`define HWF_DEFINES_SVH

// ----------------------------------------------------------------
// feature control register bit positions
// ----------------------------------------------------------------
`define HWF_B_CLKSEL    6
`define HWF_B_NOPRE     7
`define HWF_B_DOZE      8
`define HWF_B_NAP       9
`define HWF_B_SLEEP     10
`define HWF_B_DPM       11
`define HWF_B_ICE       16
`define HWF_B_DCE       17
`define HWF_B_INSTR_CACHE_FREEZE     18
`define HWF_B_DATA_CACHE_FREEZE     19
`define HWF_B_INSTR_CACHE_FLUSH_ALL      20
`define HWF_WR_MASK     32'h001F0FC0
`define HWF_CTL_RESET   32'h00000000

// ----------------------------------------------------------------
// timing and encodings
// ----------------------------------------------------------------
`define HWF_SLEEP_DELAY 8'h04
`define HWF_PLL_SETTLE  8'h02
`define HWF_PLL_BYPASS  4'hF
`define HWF_PLL_RESET   4'h0
`define HWF_CLK_HARD_RESET_N  2'h0

// ----------------------------------------------------------------
// system logic apb registers
// ----------------------------------------------------------------
`define HWF_A_CTRL      8'h00
`define HWF_A_STATUS    8'h04
`define HWF_A_PLLCFG    8'h08
`define HWF_C_GRANT     0
`define HWF_C_PLLOFF    1
`define HWF_C_RESTORE   2
`define HWF_CTRL_RESET  3'h0

`endif

//--- hwf_pkg.sv
package hwf_pkg;

	typedef enum logic [2:0] {
		PWR_RUN    = 3'b000,
		PWR_DOZE   = 3'b001,
		PWR_NAP    = 3'b010,
		PWR_SLPREQ = 3'b011,
		PWR_SLPWT  = 3'b100,
		PWR_SLEEP  = 3'b101
	} hwf_pwr_t;

	typedef enum logic [1:0] {
		SYS_IDLE    = 2'b00,
		SYS_GRANT   = 2'b01,
		SYS_BYPASS  = 2'b10,
		SYS_STOPPED = 2'b11
	} hwf_sys_t;

endpackage : hwf_pkg

//--- hwf_link_if.sv
`timescale 1ns/1ps
interface hwf_link_if (
	input wire logic CLK,
	input wire logic RST_N
);
	logic       quiesce_request_n;
	logic       quiesce_grant_n;
	logic       retry_dev_o;
	logic       retry_dev_oe_n;
	logic       retry_host_o;
	logic       retry_host_oe_n;
	logic       address_retry_n;
	logic       retry_keep;
	logic [3:0] pll_cfg;
	logic       system_clock_in;

	// ----------------------------------------------------------------
	// shared retry line: device wins, undriven line keeps its level
	// ----------------------------------------------------------------
	always_comb begin
		if (!retry_dev_oe_n)
			address_retry_n = retry_dev_o;
		else if (!retry_host_oe_n)
			address_retry_n = retry_host_o;
		else
			address_retry_n = retry_keep;
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N)
			retry_keep <= 1'b1;
		else
			retry_keep <= address_retry_n;
	end

	modport dev (
		output quiesce_request_n, retry_dev_o, retry_dev_oe_n,
		input  quiesce_grant_n, address_retry_n, pll_cfg, system_clock_in
	);

	modport host (
		input  quiesce_request_n, address_retry_n,
		output quiesce_grant_n, retry_host_o, retry_host_oe_n, pll_cfg, system_clock_in
	);

endinterface : hwf_link_if

//--- hwf_syslogic.sv
`timescale 1ns/1ps
`include "hwf_defines.svh"
module hwf_syslogic (
	input  wire logic        CLK,
	input  wire logic        RST_N,
	hwf_link_if.host         LINK,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR
);
	import hwf_pkg::*;

	typedef struct packed {
		logic [2:0]  ctrl;
		logic [3:0]  cfg;
		hwf_sys_t    sys;
		logic [7:0]  cnt;
		logic        grant_n;
		logic [3:0]  pll;
		logic        clk_run;
		logic        rty_o;
		logic        rty_oe_n;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} hwf_sys_st_t;

	hwf_sys_st_t st_r;
	hwf_sys_st_t st_nxt;
	logic        acc;

	always_comb begin
		st_nxt = st_r;
		acc    = PSEL && PENABLE;

		// ----------------------------------------------------------------
		// apb slave: one wait state, write lands with pready
		// ----------------------------------------------------------------
		st_nxt.pready  = acc && !st_r.pready;
		st_nxt.pslverr = 1'b0;
		if (acc && !st_r.pready) begin
			st_nxt.prdata = 32'h00000000;
			unique case (PADDR)
				`HWF_A_CTRL:   st_nxt.prdata = {29'h0, st_r.ctrl};
				`HWF_A_STATUS: st_nxt.prdata = {27'h0, LINK.address_retry_n, st_r.sys,
				                                ~st_r.clk_run, ~LINK.quiesce_request_n};
				`HWF_A_PLLCFG: st_nxt.prdata = {28'h0, st_r.cfg};
				default:       st_nxt.pslverr = 1'b1;
			endcase
		end
		if (acc && st_r.pready && PWRITE) begin
			if (PADDR == `HWF_A_CTRL)
				st_nxt.ctrl = PWDATA[2:0];
			if (PADDR == `HWF_A_PLLCFG) begin
				st_nxt.cfg = PWDATA[3:0];
				if (st_r.sys == SYS_IDLE)
					st_nxt.pll = PWDATA[3:0];
			end
		end

		// ----------------------------------------------------------------
		// sleep grant and pll shutdown
		// ----------------------------------------------------------------
		unique case (st_r.sys)
			SYS_IDLE: begin
				if (!LINK.quiesce_request_n && st_r.ctrl[`HWF_C_GRANT]) begin
					st_nxt.grant_n = 1'b0;
					st_nxt.sys     = SYS_GRANT;
					st_nxt.cnt     = '0;
				end
			end
			SYS_GRANT: begin
				if (st_r.cnt != 8'hFF)
					st_nxt.cnt = st_r.cnt + 8'h01;
				if (LINK.quiesce_request_n) begin
					st_nxt.grant_n = 1'b1;
					st_nxt.sys     = SYS_IDLE;
				end else if (st_r.ctrl[`HWF_C_PLLOFF]
				             && st_r.cnt >= `HWF_SLEEP_DELAY + `HWF_PLL_SETTLE) begin
					st_nxt.pll = `HWF_PLL_BYPASS;
					st_nxt.sys = SYS_BYPASS;
				end
			end
			SYS_BYPASS: begin
				st_nxt.clk_run = 1'b0;
				st_nxt.sys     = SYS_STOPPED;
			end
			SYS_STOPPED: begin
				if (LINK.quiesce_request_n) begin
					st_nxt.clk_run = 1'b1;
					st_nxt.pll     = st_r.cfg;
					st_nxt.grant_n = 1'b1;
					st_nxt.sys     = SYS_IDLE;
				end
			end
		endcase

		// ----------------------------------------------------------------
		// retry line restore when the device does not precharge
		// ----------------------------------------------------------------
		st_nxt.rty_o    = 1'b1;
		st_nxt.rty_oe_n = !(st_r.ctrl[`HWF_C_RESTORE] && !LINK.address_retry_n);
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			st_r          <= '0;
			st_r.ctrl     <= `HWF_CTRL_RESET;
			st_r.cfg      <= `HWF_PLL_RESET;
			st_r.pll      <= `HWF_PLL_RESET;
			st_r.sys      <= SYS_IDLE;
			st_r.grant_n  <= 1'b1;
			st_r.clk_run  <= 1'b1;
			st_r.rty_o    <= 1'b1;
			st_r.rty_oe_n <= 1'b1;
		end else
			st_r <= st_nxt;
	end

	assign PRDATA               = st_r.prdata;
	assign PREADY               = st_r.pready;
	assign PSLVERR              = st_r.pslverr;
	assign LINK.quiesce_grant_n = st_r.grant_n;
	assign LINK.pll_cfg         = st_r.pll;
	assign LINK.system_clock_in = st_r.clk_run;
	assign LINK.retry_host_o    = st_r.rty_o;
	assign LINK.retry_host_oe_n = st_r.rty_oe_n;

endmodule : hwf_syslogic

//--- hwf_chk_sva.sv
`timescale 1ns/1ps
`include "hwf_defines.svh"
module hwf_chk_sva (
	input wire logic       CLK,
	input wire logic       RST_N,
	input wire logic       quiesce_request_n,
	input wire logic       quiesce_grant_n,
	input wire logic       retry_dev_o,
	input wire logic       retry_dev_oe_n,
	input wire logic       retry_host_o,
	input wire logic       retry_host_oe_n,
	input wire logic       address_retry_n,
	input wire logic [3:0] pll_cfg,
	input wire logic       system_clock_in
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);

	property p_drv_lo;
		$fell(retry_dev_oe_n) |-> !retry_dev_o ##2 retry_dev_oe_n;
	endproperty
	a_drv_lo: assert property (p_drv_lo) else $error("retry drive not low then released");

	property p_pre_hi;
		!retry_dev_oe_n && retry_dev_o |-> $past(!retry_dev_oe_n) && !$past(retry_dev_o);
	endproperty
	a_pre_hi: assert property (p_pre_hi) else $error("retry precharge without low drive");

	property p_host_one;
		!retry_host_oe_n |-> retry_host_o;
	endproperty
	a_host_one: assert property (p_host_one) else $error("system logic drives retry low");

	property p_host_cause;
		$fell(retry_host_oe_n) |-> $past(!address_retry_n);
	endproperty
	a_host_cause: assert property (p_host_cause) else $error("retry restore without low line");

	property p_grant_cause;
		$fell(quiesce_grant_n) |-> $past(!quiesce_request_n);
	endproperty
	a_grant_cause: assert property (p_grant_cause) else $error("grant without request");

	property p_grant_hold;
		!quiesce_grant_n && !quiesce_request_n |=> !quiesce_grant_n;
	endproperty
	a_grant_hold: assert property (p_grant_hold) else $error("grant dropped under request");

	property p_byp_first;
		$fell(system_clock_in) |-> $past(pll_cfg) == `HWF_PLL_BYPASS && pll_cfg == `HWF_PLL_BYPASS;
	endproperty
	a_byp_first: assert property (p_byp_first) else $error("clock stopped before bypass");

	property p_stop_late;
		$fell(system_clock_in) |-> $past(!quiesce_grant_n, 5);
	endproperty
	a_stop_late: assert property (p_stop_late) else $error("clock stopped too early");
endmodule : hwf_chk_sva

//--- tb_hw_feature_control_bits.sv
`timescale 1ns/1ps
`include "hwf_defines.svh"
module tb_hw_feature_control_bits;
	import hwf_pkg::*;
	localparam int SETS = 8;
	localparam int SW = $clog2(SETS);
	typedef struct {int s; logic [32:0] v;} hwf_note_t;
	// ------
	// signals
	// ------
	logic CLK, RST_N, SPR_WE, MACHINE_STATE_LOWPWR_BIT, WAKE, HARD_RESET_N, CLKOUT_TYPE_SEL_B;
	logic RETRY_REQ, ACC_VALID, ACC_INSTR, ACC_WAY, ACC_TAG_HIT, ACC_XLATE_CI, PSEL, PENABLE;
	logic SNP_VALID, SNP_INSTR, SNP_WAY, SNP_TAG_HIT, SNP_KILL, PWRITE, PREADY, PSLVERR;
	logic CLK_OUT_EN, CORE_ACTIVE, SNOOP_ACTIVE, PLL_TB_ACTIVE, RES_VALID, RES_HIT, RES_FILL;
	logic RES_SINGLE_BEAT, CACHE_INHIBIT_PIN, SNP_HIT, FLUSH_BUSY;
	logic [SW-1:0]     ACC_SET, SNP_SET;
	logic [31:0]       SPR_WDATA, SPR_RDATA, PWDATA, PRDATA;
	logic [7:0]        PADDR;
	logic [3:0]        UNIT_IDLE, UNIT_LOWPWR;
	logic [1:0]        CLK_OUT_SEL;
	hwf_pwr_t          PWR_STATE;
	hwf_note_t         qp[$];
	logic [3:0]        qa[$];
	logic [32:0]       qr[$];
	logic [2*SETS-1:0] vld[2];
	int                seed = 43709;
	int                n_mismatch = 0;
	int                check_count = 0;
	int                cyc = 0;

	hwf_link_if lnk (.CLK, .RST_N);
	hwf_device #(.SETS(SETS), .NUNITS(4)) i_hwf_device (.CLK, .RST_N, .LINK(lnk), .SPR_WE,
		.SPR_WDATA, .SPR_RDATA, .MACHINE_STATE_LOWPWR_BIT, .WAKE, .HARD_RESET_N,
		.CLKOUT_TYPE_SEL_B, .CLK_OUT_EN, .CLK_OUT_SEL, .PWR_STATE, .CORE_ACTIVE, .SNOOP_ACTIVE,
		.PLL_TB_ACTIVE, .UNIT_IDLE, .UNIT_LOWPWR, .RETRY_REQ, .ACC_VALID, .ACC_INSTR, .ACC_SET,
		.ACC_WAY, .ACC_TAG_HIT, .ACC_XLATE_CI, .RES_VALID, .RES_HIT, .RES_FILL,
		.RES_SINGLE_BEAT, .CACHE_INHIBIT_PIN, .SNP_VALID, .SNP_INSTR, .SNP_SET, .SNP_WAY,
		.SNP_TAG_HIT, .SNP_KILL, .SNP_HIT, .FLUSH_BUSY);
	hwf_syslogic i_hwf_syslogic (.CLK, .RST_N, .LINK(lnk), .PSEL, .PENABLE, .PWRITE, .PADDR,
		.PWDATA, .PRDATA, .PREADY, .PSLVERR);
	hwf_chk_sva chk (.CLK, .RST_N, .quiesce_request_n(lnk.quiesce_request_n),
		.quiesce_grant_n(lnk.quiesce_grant_n), .retry_dev_o(lnk.retry_dev_o),
		.retry_dev_oe_n(lnk.retry_dev_oe_n), .retry_host_o(lnk.retry_host_o),
		.retry_host_oe_n(lnk.retry_host_oe_n), .address_retry_n(lnk.address_retry_n),
		.pll_cfg(lnk.pll_cfg), .system_clock_in(lnk.system_clock_in));

	initial begin
		CLK = 1'b0;
		forever #50 CLK = ~CLK;
	end
	// ------
	// tasks
	// ------
	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : finish_test

	task automatic check(string nm, logic [32:0] seen, logic [32:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task automatic tick(int n);
		repeat (n) @(posedge CLK);
	endtask : tick

	task automatic note(int s, logic [32:0] v);
		qp.push_back('{s, v});
	endtask : note

	task automatic done(string t);
		$display("test %s done", t);
	endtask : done

	task automatic spr(logic [31:0] d);
		SPR_WE <= 1'b1;
		SPR_WDATA <= d;
		tick(1);
		SPR_WE <= 1'b0;
	endtask : spr

	task automatic apb(logic wr, logic [7:0] a, logic [31:0] d, logic [32:0] exp);
		{PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= {2'b10, wr, a, d};
		tick(1);
		PENABLE <= 1'b1;
		if (!wr) qr.push_back(exp);
		do tick(1); while (PREADY !== 1'b1);
		{PSEL, PENABLE} <= 2'b00;
		tick(1);
	endtask : apb

	task automatic wake();
		{MACHINE_STATE_LOWPWR_BIT, WAKE} <= 2'b01;
		tick(1);
		WAKE <= 1'b0;
		note(1, 33'(PWR_RUN));
		note(5, 33'h3);
	endtask : wake

	task automatic rnd(int n);
		logic [31:0] r;
		logic [31:0] cfg;
		logic [SW:0] a;
		logic        h, f, ins, x, en, lk;
		cfg = 32'h0;
		for (int i = 0; i < n; i++) begin
			r = $random(seed);
			if (i % 8 == 0) begin
				cfg = {12'h0, r[19:16], 4'h0, r[11], 11'h0};
				{ACC_VALID, SNP_VALID} <= 2'h0;
				spr(cfg);
			end
			{ACC_INSTR, ACC_SET, ACC_WAY, ACC_TAG_HIT, ACC_XLATE_CI} <= r[SW+4:1];
			{SNP_INSTR, SNP_SET, SNP_WAY, SNP_TAG_HIT, SNP_KILL} <= r[SW+4:1];
			{ACC_VALID, SNP_VALID} <= {r[0], !r[0]};
			UNIT_IDLE <= r[31:28];
			ins = r[SW+4];
			a = r[SW+3:3];
			x = r[1];
			en = ins ? cfg[16] : cfg[17];
			lk = ins ? cfg[18] : cfg[19];
			h = en && r[2] && vld[ins][a];
			f = en && !h && !lk && !x;
			tick(1);
			if (r[0]) begin
				qa.push_back({h, f, !h && !f, x});
				if (f) vld[ins][a] = 1'b1;
			end else begin
				note(8, 33'(h));
				if (h && x) vld[ins][a] = 1'b0;
			end
		end
		{ACC_VALID, SNP_VALID} <= 2'h0;
		tick(1);
	endtask : rnd
	// ------
	// monitor
	// ------
	function automatic logic [32:0] view(int s);
		case (s)
			0: return 33'(SPR_RDATA);
			1: return 33'(PWR_STATE);
			2: return 33'({CORE_ACTIVE, SNOOP_ACTIVE, PLL_TB_ACTIVE});
			3: return 33'(FLUSH_BUSY);
			4: return 33'({CLK_OUT_EN, CLK_OUT_SEL});
			5: return 33'({lnk.address_retry_n, lnk.quiesce_request_n});
			6: return 33'({lnk.system_clock_in, lnk.pll_cfg});
			7: return 33'(UNIT_LOWPWR);
			default: return 33'(SNP_HIT);
		endcase
	endfunction : view

	always @(negedge CLK) begin : mon
		hwf_note_t n;
		while (qp.size() > 0) begin
			n = qp.pop_front();
			check($sformatf("view%0d", n.s), view(n.s), n.v);
		end
		if (RES_VALID === 1'b1)
			check("access", 33'({RES_HIT, RES_FILL, RES_SINGLE_BEAT, CACHE_INHIBIT_PIN}),
				33'(qa.pop_front()));
		if (PSEL && PENABLE && PREADY === 1'b1 && !PWRITE)
			check("apb", {PSLVERR, PSLVERR ? 32'h0 : PRDATA}, qr.pop_front());
	end

	always @(posedge CLK) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_mismatch++;
			finish_test();
		end
	end
	// ------
	// main sequence
	// ------
	initial begin
		{RST_N, SPR_WE, MACHINE_STATE_LOWPWR_BIT, WAKE, RETRY_REQ, CLKOUT_TYPE_SEL_B} = '0;
		{ACC_VALID, ACC_INSTR, ACC_SET, ACC_WAY, ACC_TAG_HIT, ACC_XLATE_CI} = '0;
		{SNP_VALID, SNP_INSTR, SNP_SET, SNP_WAY, SNP_TAG_HIT, SNP_KILL} = '0;
		{PSEL, PENABLE, PWRITE, PADDR, PWDATA, SPR_WDATA, UNIT_IDLE} = '0;
		HARD_RESET_N = 1'b1;
		vld[0] = '0;
		vld[1] = '0;
		tick(12);
		RST_N <= 1'b1;
		tick(1);
		note(0, 33'h0);
		note(1, 33'(PWR_RUN));
		note(2, 33'h7);
		spr(32'hFFEFFFFF);
		note(0, 33'h000F0FC0);
		done("reset");
		for (int k = 0; k < 4; k++) begin
			CLKOUT_TYPE_SEL_B <= k[1];
			spr({25'h0, k[0], 6'h0});
			tick(2);
			note(4, 33'({k[1:0] != 2'h0, k[1:0]}));
		end
		HARD_RESET_N <= 1'b0;
		tick(2);
		note(4, 33'h4);
		HARD_RESET_N <= 1'b1;
		spr(32'h800);
		for (int k = 0; k < 4; k++) begin
			UNIT_IDLE <= 4'($random(seed));
			tick(1);
			note(7, 33'(UNIT_IDLE));
		end
		spr(32'h0);
		UNIT_IDLE <= 4'hF;
		tick(1);
		note(7, 33'h0);
		done("clkout_dpm");
		apb(1'b1, `HWF_A_CTRL, 32'h4, 33'h0);
		apb(1'b0, `HWF_A_CTRL, 32'h0, 33'h4);
		for (int k = 0; k < 2; k++) begin
			spr(32'(k) << 7);
			RETRY_REQ <= 1'b1;
			tick(1);
			RETRY_REQ <= 1'b0;
			note(5, 33'h1);
			tick(1);
			note(5, 33'h3);
		end
		done("retry");
		for (int k = 0; k < 2; k++) begin
			spr(32'h100 << k);
			MACHINE_STATE_LOWPWR_BIT <= 1'b1;
			tick(1);
			note(1, 33'(k ? PWR_NAP : PWR_DOZE));
			note(2, 33'(k ? 3'h1 : 3'h3));
			wake();
		end
		spr(32'h400);
		MACHINE_STATE_LOWPWR_BIT <= 1'b1;
		tick(1);
		note(5, 33'h2);
		tick(4);
		note(1, 33'(PWR_SLPREQ));
		apb(1'b1, `HWF_A_CTRL, 32'h7, 33'h0);
		for (int i = 0; i < 40 && PWR_STATE !== PWR_SLEEP; i++) tick(1);
		note(1, 33'(PWR_SLEEP));
		note(2, 33'h0);
		tick(12);
		note(6, 33'(`HWF_PLL_BYPASS));
		apb(1'b0, 8'h0C, 32'h0, 33'h100000000);
		wake();
		done("power");
		rnd(60);
		spr(32'h00100000);
		tick(2);
		note(0, 33'h00100000);
		note(3, 33'h0);
		spr(32'h00110000);
		note(0, 33'h00110000);
		spr(32'h00010000);
		note(0, 33'h00010000);
		note(3, 33'h1);
		{ACC_VALID, ACC_INSTR, ACC_TAG_HIT, ACC_XLATE_CI} <= 4'hE;
		{SNP_VALID, SNP_INSTR, SNP_TAG_HIT} <= 3'h7;
		qa.push_back(4'h2);
		tick(1);
		note(8, 33'h0);
		{ACC_VALID, SNP_VALID} <= 2'h0;
		vld[1] = '0;
		tick(SETS + 2);
		note(3, 33'h0);
		rnd(60);
		done("cache");
		check("pending", 33'(qa.size() + qp.size()), 33'h0);
		finish_test();
	end
endmodule : tb_hw_feature_control_bits
